// *** shared/snfe_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// link wires between host and flash front end
// =====================================================================
interface snfe_link_if;
   logic sclk;
   logic cs_n;
   logic [3:0] host_out;
   logic [3:0] host_oe;
   logic [3:0] dev_out;
   logic [3:0] dev_oe;
   logic [3:0] lane;

   // resolved lane level; an undriven lane floats to a weak pull-up
   assign lane = (dev_oe & dev_out) | (~dev_oe & host_oe & host_out) |
                 (~dev_oe & ~host_oe);

   modport host (output sclk, output cs_n, output host_out,
                 output host_oe, input lane);
   modport dev (input sclk, input cs_n, input lane,
                output dev_out, output dev_oe);
endinterface : snfe_link_if
`default_nettype wire

// *** shared/snfe_pkg.sv ***
// =====================================================================
// shared constants and helpers for the serial nand front end
// =====================================================================
package snfe_pkg;

   // lane width of one clock: one, two or four bits
   typedef logic [2:0] snfe_width_t;
   localparam snfe_width_t W1 = 3'h1;
   localparam snfe_width_t W2 = 3'h2;
   localparam snfe_width_t W4 = 3'h4;

   // opcodes, always sent on lane 0
   localparam logic [7:0] CMD_GET_FEAT = 8'h0f;
   localparam logic [7:0] CMD_SET_FEAT = 8'h1f;
   localparam logic [7:0] CMD_READ_X1 = 8'h03;
   localparam logic [7:0] CMD_READ_X2 = 8'h3b;
   localparam logic [7:0] CMD_READ_X4 = 8'h6b;
   localparam logic [7:0] CMD_LOAD_X1 = 8'h02;
   localparam logic [7:0] CMD_LOAD_X4 = 8'h32;

   // feature addresses and power-up values
   localparam logic [7:0] FEAT_PROTECT = 8'ha0;
   localparam logic [7:0] FEAT_CONFIG = 8'hb0;
   localparam logic [7:0] PROTECT_RESET = 8'h38;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] FEAT_NONE = 8'h00;
   localparam int GUARD_BIT = 7;
   localparam int QE_BIT = 0;

   // lane roles
   localparam int SI_LANE = 0;
   localparam int SO_LANE = 1;
   localparam int WP_LANE = 2;
   localparam int HOLD_LANE = 3;
   localparam logic [3:0] LANE_ALL = 4'hf;
   localparam logic [3:0] MASK_X1_OUT = 4'h2;

   // opcode byte plus address byte precede data
   localparam int HDR_BYTES = 2;

   typedef enum logic [4:0] {
      DS_CMD = 5'h01,
      DS_ADDR = 5'h02,
      DS_DIN = 5'h04,
      DS_DOUT = 5'h08,
      DS_IGNORE = 5'h10
   } snfe_dev_state_t;

   typedef enum logic [3:0] {
      HS_IDLE = 4'h1,
      HS_SETUP = 4'h2,
      HS_SHIFT = 4'h4,
      HS_GAP = 4'h8
   } snfe_host_state_t;

   function automatic snfe_width_t data_width(input logic [7:0] cmd);
      case (cmd)
         CMD_READ_X2: data_width = W2;
         CMD_READ_X4, CMD_LOAD_X4: data_width = W4;
         default: data_width = W1;
      endcase
   endfunction : data_width

   function automatic logic is_known(input logic [7:0] cmd);
      case (cmd)
         CMD_GET_FEAT, CMD_SET_FEAT, CMD_READ_X1, CMD_READ_X2,
         CMD_READ_X4, CMD_LOAD_X1, CMD_LOAD_X4: is_known = 1'b1;
         default: is_known = 1'b0;
      endcase
   endfunction : is_known

   function automatic logic is_write(input logic [7:0] cmd);
      is_write = (cmd == CMD_SET_FEAT) || (cmd == CMD_LOAD_X1) ||
                 (cmd == CMD_LOAD_X4);
   endfunction : is_write

   // msb-first slice of a byte at bit position pos, highest lane first
   function automatic logic [3:0] lane_slice(input logic [7:0] b,
      input logic [2:0] pos, input snfe_width_t w);
      logic [7:0] s;
      s = b << pos;
      case (w)
         W1: lane_slice = {3'h0, s[7]};
         W2: lane_slice = {2'h0, s[7:6]};
         default: lane_slice = s[7:4];
      endcase
   endfunction : lane_slice

   function automatic logic [7:0] shift_in(input logic [7:0] b,
      input logic [3:0] lanes, input snfe_width_t w);
      case (w)
         W1: shift_in = {b[6:0], lanes[0]};
         W2: shift_in = {b[5:0], lanes[1:0]};
         default: shift_in = {b[3:0], lanes};
      endcase
   endfunction : shift_in

endpackage : snfe_pkg

// *** verification/snfe_link_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// link rules, oversampled on the reference clock
// =====================================================================
module snfe_link_chk (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] host_out,
   input wire logic [3:0] host_oe,
   input wire logic [3:0] dev_out,
   input wire logic [3:0] dev_oe,
   input wire logic [3:0] lane
);
   // link edges sit many reference cycles apart, so edges show as $fell
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   AST_DESELECT_FLOAT: assert property (cs_n |-> dev_oe == 4'h0)
      else $error("device drives a lane while deselected");
   AST_OUT_AFTER_FALL: assert property (!cs_n && !$past(cs_n) &&
      $changed(dev_out) |-> $fell(sclk))
      else $error("device output moved away from a clock fall");
   AST_DRIVE_STARTS_ON_FALL: assert property (!cs_n &&
      $rose(|dev_oe) && $stable(lane[3]) |-> $fell(sclk))
      else $error("device began driving away from a clock fall");
   AST_NO_CONTENTION: assert property ((dev_oe & host_oe) == 4'h0)
      else $error("host and device drive the same lane");
   AST_LANE_MASK: assert property (dev_oe inside {4'h0, 4'h2,
      4'h3, 4'hf})
      else $error("device drives an illegal lane set");
   AST_SELECT_IDLE_LOW: assert property ($fell(cs_n) |-> !sclk)
      else $error("clock not idle low when selecting");
   AST_RELEASE_IDLE_LOW: assert property ($rose(cs_n) |-> !sclk)
      else $error("clock not idle low when deselecting");
   AST_HOST_STEADY: assert property ($rose(sclk) |->
      $stable(host_out[0]))
      else $error("host lane 0 moved on a rising clock");

   // main scenarios: frame end, device read drive, pause held by host
   cover property ($rose(cs_n));
   cover property ($rose(|dev_oe));
   cover property (!cs_n && !sclk && !lane[3] && dev_oe == 4'h0);
endmodule : snfe_link_chk
`default_nettype wire

// *** verification/snfe_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
   end end
// =====================================================================
// host and flash end joined back to back
// =====================================================================
module testbench;
   import snfe_pkg::*;
   logic i_ref_clk, i_rst_n, i_start, i_pause, i_wp_n;
   logic o_busy, o_wdata_take, o_rdata_valid, o_paused;
   logic [7:0] i_cmd, i_addr, i_len, i_wdata, o_rdata, o_protect, o_config;
   logic [7:0] wq [2];
   logic [7:0] rq [$];
   int widx = 0;
   int cyc = 0;
   int n_mismatch = 0;
   int checked = 0;

   snfe_link_if snfe_link_if_i ();
   snfe_host snfe_host_i (.i_ref_clk, .i_rst_n, .i_start, .i_cmd, .i_addr,
      .i_len, .i_wdata, .i_pause, .i_wp_n, .o_busy, .o_wdata_take,
      .o_rdata_valid, .o_rdata, .link(snfe_link_if_i.host));
   snfe_device snfe_device_i (.link(snfe_link_if_i.dev), .i_rst_n,
      .o_protect, .o_config, .o_paused);
   snfe_link_chk snfe_link_chk_i (.i_ref_clk, .i_rst_n,
      .sclk(snfe_link_if_i.sclk), .cs_n(snfe_link_if_i.cs_n),
      .host_out(snfe_link_if_i.host_out), .host_oe(snfe_link_if_i.host_oe),
      .dev_out(snfe_link_if_i.dev_out), .dev_oe(snfe_link_if_i.dev_oe),
      .lane(snfe_link_if_i.lane));

   // =================================================================
   // clock, write feed, read capture, hang guard
   // =================================================================
   initial begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   assign i_wdata = wq[widx[0]];
   // next byte only after the host took the current one
   always @(posedge i_ref_clk) begin
      if (o_wdata_take === 1'b1) #1 widx = widx + 1;
   end
   always @(posedge i_ref_clk) begin
      if (o_rdata_valid === 1'b1) rq.push_back(o_rdata);
   end
   // about twenty frames of some 700 cycles each fit well below this
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         print_verdict;
      end
   end

   // =================================================================
   // one whole frame; reads compare what came back
   // =================================================================
   task automatic xfer(input logic [7:0] c, a, input int n, input bit wr,
      input logic [7:0] b0, b1);
      int k;
      wq[0] = b0;
      wq[1] = b1;
      widx = 0;
      rq.delete();
      i_cmd = c;
      i_addr = a;
      i_len = n[7:0];
      i_start = 1'b1;
      @(posedge i_ref_clk);
      #1 i_start = 1'b0;
      for (k = 0; k < 3000 && o_busy !== 1'b0; k++) @(posedge i_ref_clk);
      repeat (2) @(posedge i_ref_clk);
      #1;
      `CHK(o_busy, 1'b0);
      if (!wr) begin
         `CHK(rq.size(), n);
         `CHK(rq[0], b0);
         if (n > 1) `CHK(rq[1], b1);
      end
   endtask : xfer

   // host pauses mid data phase; exp says whether the device obeys
   task automatic paused_read(input logic exp);
      fork
         xfer(CMD_READ_X1, 8'h00, 2, 1'b0, 8'ha5, 8'h3c);
         begin
            repeat (420) @(posedge i_ref_clk);
            #1 i_pause = 1'b1;
            repeat (100) @(posedge i_ref_clk);
            `CHK(o_paused, exp);
            #1 i_pause = 1'b0;
            repeat (60) @(posedge i_ref_clk);
            `CHK(o_paused, 1'b0);
         end
      join
   endtask : paused_read

   task print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // =================================================================
   // main sequence
   // =================================================================
   initial begin
      // start high so the fall is a real edge for the flash end too,
      // which has no clock to catch a missed reset later
      i_rst_n = 1'b1;
      i_start = 1'b0;
      i_pause = 1'b0;
      i_wp_n = 1'b1;
      i_cmd = 8'h00;
      i_addr = 8'h00;
      i_len = 8'h00;
      wq[0] = 8'h00;
      wq[1] = 8'h00;
      #1 i_rst_n = 1'b0;
      repeat (12) @(posedge i_ref_clk);
      #1 i_rst_n = 1'b1;
      @(posedge i_ref_clk);
      #1;
      `CHK(o_protect, PROTECT_RESET);
      xfer(CMD_GET_FEAT, FEAT_PROTECT, 1, 1'b0, 8'h38, 8'h00);
      xfer(CMD_GET_FEAT, FEAT_CONFIG, 1, 1'b0, 8'h00, 8'h00);
      xfer(CMD_SET_FEAT, FEAT_PROTECT, 1, 1'b1, 8'hb8, 8'h00);
      xfer(CMD_GET_FEAT, FEAT_PROTECT, 1, 1'b0, 8'hb8, 8'h00);
      i_wp_n = 1'b0;
      xfer(CMD_SET_FEAT, FEAT_PROTECT, 1, 1'b1, 8'h00, 8'h00);
      xfer(CMD_GET_FEAT, FEAT_PROTECT, 1, 1'b0, 8'hb8, 8'h00);
      i_wp_n = 1'b1;
      xfer(CMD_SET_FEAT, FEAT_PROTECT, 1, 1'b1, 8'h38, 8'h00);
      `CHK(o_protect, 8'h38);
      xfer(CMD_LOAD_X1, 8'h00, 2, 1'b1, 8'ha5, 8'h3c);
      xfer(CMD_READ_X1, 8'h00, 2, 1'b0, 8'ha5, 8'h3c);
      xfer(CMD_READ_X2, 8'h00, 2, 1'b0, 8'ha5, 8'h3c);
      // refused: nobody drives, so the pull-ups give all ones
      xfer(CMD_READ_X4, 8'h00, 1, 1'b0, 8'hff, 8'h00);
      xfer(CMD_SET_FEAT, FEAT_CONFIG, 1, 1'b1, 8'h01, 8'h00);
      `CHK(o_config, 8'h01);
      xfer(CMD_LOAD_X4, 8'h04, 2, 1'b1, 8'h96, 8'h0f);
      xfer(CMD_READ_X4, 8'h04, 2, 1'b0, 8'h96, 8'h0f);
      paused_read(1'b0);
      xfer(CMD_SET_FEAT, FEAT_CONFIG, 1, 1'b1, 8'h00, 8'h00);
      `CHK(o_config, 8'h00);
      paused_read(1'b1);
      print_verdict;
   end
endmodule : testbench
`default_nettype wire

// *** verilog/snfe_device.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - single lane, host bits sampled on rising edges
// - read bits change after falling clock edges
// - modes 0 and 3 both accepted
// - two-lane commands use lanes 0 and 1
// - four-lane commands add lanes 2 and 3
// - four-lane opcodes accepted only with quad enable
// - deselected means every lane released
// - falling select starts a command; background continues
// - lane 0 takes opcode, address, data; drives wide reads
// - lane 1 takes wide data; drives reads
// - guard set and protect pin low blocks feature writes outside quad mode
// - host pauses only while selected
// - pause starts on pin fall or next clock fall
// - pause ends on pin rise or next clock fall
// - paused: output released, clock and input ignored
// - select must stay low while paused
// - quad enable disables pause, pin is lane 3
// - feature registers reached by get and set feature
// - guard bit is bit 7 at a0, resets 0
// =====================================================================
// flash end: all logic runs on the host's serial clock
// =====================================================================
module snfe_device #(
   parameter int BUF_DEPTH = 16
) (
   snfe_link_if.dev link,
   input wire logic i_rst_n,
   output logic [7:0] o_protect,
   output logic [7:0] o_config,
   output logic o_paused
);
   import snfe_pkg::*;

   localparam int PTR_W = $clog2(BUF_DEPTH);

   // page-buffer stand-in, kept across frames and pauses
   logic [7:0] buf_mem [BUF_DEPTH];

   snfe_dev_state_t state;
   logic [7:0] cmd, addr, rx_sh, rd_byte, protect, config_reg;
   logic [7:0] next_rx, feat_rd, rd_next, feat_addr;
   logic [PTR_W-1:0] ptr, rd_idx;
   logic [2:0] pos;
   logic [3:0] pos_sum, slice, drv_bits, drv_mask;
   snfe_width_t w;
   logic byte_done, quad_enable, hold_gate, hold_fall, paused;
   logic wp_blocks, drv_en, feat_wr, load_wr;

   // ==================================================================
   // lane width, bit counting and pause detection
   // ==================================================================
   assign quad_enable = config_reg[QE_BIT];
   // opcode and address always come one bit a clock on lane 0
   assign w = (state == DS_DIN || state == DS_DOUT) ?
              data_width(cmd) : W1;
   assign pos_sum = {1'b0, pos} + {1'b0, w};
   assign byte_done = pos_sum[3];
   assign next_rx = shift_in(rx_sh, link.lane, w);

   // pause level seen by either clock edge: the clock was just low (rise) or is now low (fall),
   // so the pin level itself decides at that instant
   assign hold_gate = !quad_enable &&
                      !link.lane[HOLD_LANE];

   // with the clock high, the level caught at the last falling edge
   // decides; with it low, the pin acts at once
   assign paused = !quad_enable && !link.cs_n &&
                   (link.sclk ? hold_fall : !link.lane[HOLD_LANE]);
   assign o_paused = paused;

   // write protection: the protect pin counts only outside quad mode
   assign wp_blocks = protect[GUARD_BIT] && !quad_enable &&
                      !link.lane[WP_LANE];

   // ==================================================================
   // command decoder; select high clears it at once
   // ==================================================================
   // edges only, so either idle clock level works
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         state <= DS_CMD;
         pos <= 3'h0;
         rx_sh <= 8'h00;
         cmd <= 8'h00;
         addr <= 8'h00;
         ptr <= '0;
      end else if (!hold_gate) begin
         pos <= pos_sum[2:0];
         rx_sh <= next_rx;
         if (byte_done) begin
            case (state)
               DS_CMD: begin
                  cmd <= next_rx;
                  // unknown opcodes and quad without enable are dropped
                  if (!is_known(next_rx) ||
                      (data_width(next_rx) == W4 && !quad_enable)) begin
                     state <= DS_IGNORE;
                  end else begin
                     state <= DS_ADDR;
                  end
               end
               DS_ADDR: begin
                  addr <= next_rx;
                  ptr <= next_rx[PTR_W-1:0];
                  state <= is_write(cmd) ? DS_DIN : DS_DOUT;
               end
               DS_DIN: ptr <= ptr + 1'b1;
               DS_DOUT: ptr <= ptr + 1'b1;
               DS_IGNORE: state <= DS_IGNORE;
               default: state <= DS_IGNORE;
            endcase
         end
      end
   end

   // ==================================================================
   // feature registers; these survive deselection
   // ==================================================================
   assign feat_wr = !link.cs_n && !hold_gate && byte_done &&
                    state == DS_DIN && cmd == CMD_SET_FEAT;

   always_ff @(posedge link.sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         protect <= PROTECT_RESET; // guard bit clear
         config_reg <= CONFIG_RESET;
      end else if (feat_wr && !wp_blocks) begin
         case (addr)
            FEAT_PROTECT: protect <= next_rx;
            FEAT_CONFIG: config_reg <= next_rx;
            default: protect <= protect;
         endcase
      end
   end

   assign o_protect = protect;
   assign o_config = config_reg;

   // ==================================================================
   // buffer load; an interrupted load resumes where it stopped
   // ==================================================================
   assign load_wr = !link.cs_n && !hold_gate && byte_done &&
                    state == DS_DIN && cmd != CMD_SET_FEAT;

   always_ff @(posedge link.sclk) begin
      if (load_wr) begin
         buf_mem[ptr] <= next_rx;
      end
   end

   // ==================================================================
   // read source: feature value or buffer byte
   // ==================================================================
   always_comb begin
      feat_addr = (state == DS_ADDR) ? next_rx : addr;
      case (feat_addr)
         FEAT_PROTECT: feat_rd = protect;
         FEAT_CONFIG: feat_rd = config_reg;
         default: feat_rd = FEAT_NONE;
      endcase
   end

   // next read byte is fetched on the rising edge that ends the last
   // one, so the falling edge after it already has it in hand
   assign rd_idx = (state == DS_ADDR) ? next_rx[PTR_W-1:0] : ptr + 1'b1;
   assign rd_next = (cmd == CMD_GET_FEAT) ? feat_rd : buf_mem[rd_idx];

   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         rd_byte <= 8'h00;
      end else if (!hold_gate && byte_done &&
                   (state == DS_ADDR || state == DS_DOUT)) begin
         rd_byte <= rd_next;
      end
   end

   // ==================================================================
   // falling-edge side: pause capture and output drive
   // ==================================================================
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         hold_fall <= 1'b0;
      end else begin
         hold_fall <= !link.lane[HOLD_LANE];
      end
   end

   // one-lane reads leave on lane 1, wider ones fill from lane 0 up
   assign slice = lane_slice(rd_byte, pos, w);

   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         drv_en <= 1'b0;
         drv_bits <= 4'h0;
         drv_mask <= 4'h0;
      end else if (!hold_gate) begin
         drv_en <= (state == DS_DOUT);
         if (w == W1) begin
            drv_bits <= {2'h0, slice[0], 1'b0};
            drv_mask <= MASK_X1_OUT;
         end else begin
            drv_bits <= slice;
            drv_mask <= ~(LANE_ALL << w);
         end
      end
   end

   // select high or pause releases the lanes without waiting for a
   // clock edge, since the host may stop the clock at any time
   assign link.dev_out = drv_bits;
   assign link.dev_oe = drv_mask &
                        {4{drv_en && !link.cs_n && !paused}};

endmodule : snfe_device
`default_nettype wire

// *** verilog/snfe_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// host end: makes the link clock by dividing i_ref_clk
// =====================================================================
module snfe_host #(
   parameter int HALF_DIV = 10,
   parameter bit CPOL = 1'b0,
   parameter int LEN_W = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [7:0] i_cmd,
   input wire logic [7:0] i_addr,
   input wire logic [LEN_W-1:0] i_len,
   input wire logic [7:0] i_wdata,
   input wire logic i_pause,
   input wire logic i_wp_n,
   output logic o_busy,
   output logic o_wdata_take,
   output logic o_rdata_valid,
   output logic [7:0] o_rdata,
   snfe_link_if.host link
);
   import snfe_pkg::*;

   localparam int DIV_W = $clog2(HALF_DIV + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);
   localparam logic [LEN_W:0] DATA_IDX = (LEN_W+1)'(HDR_BYTES);

   snfe_host_state_t state;
   logic [DIV_W-1:0] div_cnt;
   logic sclk, cs_n, hold_n, wp_q;
   logic [7:0] cmd, addr, tx_byte, rx_sh, next_rx;
   logic [2:0] pos;
   logic [3:0] pos_sum, sync1, sync2, rx_lanes, hdat, hmask;
   logic [LEN_W:0] byte_idx, last_idx, next_idx;
   snfe_width_t w;
   logic tick, fin, rise_ev, fall_ev, fin_ev, in_data, rel23, bdone;

   // ==================================================================
   // edge scheduling
   // ==================================================================
   assign tick = (div_cnt == DIV_LAST);
   assign fin = (byte_idx == last_idx);
   assign rise_ev = (state == HS_SHIFT) && tick && hold_n && !sclk && !fin;
   assign fall_ev = (state == HS_SHIFT) && tick && hold_n && sclk && !fin;
   assign fin_ev = (state == HS_SHIFT) && tick && hold_n && fin;
   assign in_data = (byte_idx >= DATA_IDX);
   assign w = in_data ? data_width(cmd) : W1;
   assign pos_sum = {1'b0, pos} + {1'b0, w};
   assign bdone = pos_sum[3];
   assign next_idx = byte_idx + 1'b1;
   // one-lane reads come back on the serial output lane
   assign rx_lanes = (w == W1) ? {3'h0, sync2[SO_LANE]} : sync2;
   assign next_rx = shift_in(rx_sh, rx_lanes, w);
   assign o_busy = (state != HS_IDLE);

   // clock, select and frame sequence; the clock freezes while paused
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= HS_IDLE;
         div_cnt <= '0;
         sclk <= CPOL;
         cs_n <= 1'b1;
      end else begin
         if (state == HS_IDLE || tick) begin
            div_cnt <= '0;
         end else if (hold_n) begin
            div_cnt <= div_cnt + 1'b1;
         end
         case (state)
            HS_IDLE: if (i_start) begin
               state <= HS_SETUP;
               cs_n <= 1'b0;
            end
            HS_SETUP: if (tick) begin
               state <= HS_SHIFT;
            end
            HS_SHIFT: begin
               if (rise_ev) begin
                  sclk <= 1'b1;
               end
               if (fall_ev) begin
                  sclk <= 1'b0;
               end
               if (fin_ev) begin
                  sclk <= CPOL; // idle level at select edge
                  cs_n <= 1'b1;
                  state <= HS_GAP;
               end
            end
            HS_GAP: if (tick) begin
               state <= HS_IDLE;
            end
            default: state <= HS_IDLE;
         endcase
      end
   end

   // byte and bit position of the frame, next byte to send
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd <= 8'h00;
         addr <= 8'h00;
         tx_byte <= 8'h00;
         pos <= 3'h0;
         byte_idx <= '0;
         last_idx <= '0;
         o_wdata_take <= 1'b0;
      end else begin
         o_wdata_take <= 1'b0;
         if (state == HS_IDLE && i_start) begin
            cmd <= i_cmd;
            addr <= i_addr;
            tx_byte <= i_cmd;
            pos <= 3'h0;
            byte_idx <= '0;
            last_idx <= {1'b0, i_len} + DATA_IDX;
         end else if (rise_ev) begin
            pos <= pos_sum[2:0];
            if (bdone) begin
               byte_idx <= next_idx;
               tx_byte <= (byte_idx == '0) ? addr : i_wdata;
               o_wdata_take <= is_write(cmd) && (next_idx >= DATA_IDX) &&
                               (next_idx != last_idx);
            end
         end
      end
   end

   // read data sampled at rising edges from synchronised lanes
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         rx_sh <= 8'h00;
         o_rdata <= 8'h00;
         o_rdata_valid <= 1'b0;
      end else begin
         sync1 <= link.lane;
         sync2 <= sync1;
         o_rdata_valid <= 1'b0;
         if (rise_ev && in_data && !is_write(cmd)) begin
            rx_sh <= next_rx;
            if (bdone) begin
               o_rdata <= next_rx;
               o_rdata_valid <= 1'b1;
            end
         end
      end
   end

   // drive data after each falling edge, first bit before the first rise
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hdat <= 4'h0;
         hmask <= 4'h0;
         wp_q <= 1'b1;
      end else begin
         wp_q <= i_wp_n;
         if (state == HS_IDLE && i_start) begin
            hdat <= lane_slice(i_cmd, 3'h0, W1);
            hmask <= ~(LANE_ALL << W1);
         end else if (fall_ev) begin
            hdat <= lane_slice(tx_byte, pos, w);
            hmask <= (in_data && !is_write(cmd)) ? 4'h0 : ~(LANE_ALL << w);
         end else if (fin_ev) begin
            hmask <= 4'h0;
         end
      end
   end

   // pause only while the clock is low; never on four-lane commands
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_n <= 1'b1;
      end else if (state != HS_SHIFT) begin
         hold_n <= 1'b1;
      end else if (hold_n && !sclk && !tick && i_pause &&
                   data_width(cmd) != W4) begin
         hold_n <= 1'b0; // select held low throughout
      end else if (!hold_n && !i_pause) begin
         hold_n <= 1'b1;
      end
   end

   // lanes 2 and 3 are released to the device during quad read data
   assign rel23 = (state == HS_SHIFT) && in_data && !is_write(cmd) &&
                  (w == W4);
   assign link.sclk = sclk;
   assign link.cs_n = cs_n;
   assign link.host_out = {hmask[3] ? hdat[3] : hold_n,
                           hmask[2] ? hdat[2] : wp_q, hdat[1:0]};
   assign link.host_oe = {~rel23, ~rel23, hmask[1:0]};

endmodule : snfe_host
`default_nettype wire
